//--- src/aoc_path.sv
// offset cancellation, offset monitor, output scaling and 2:1 interpolation
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ns

module aoc_path #(
  parameter int unsigned DS_CYC       = aoc_pkg::DS_CYC,
  parameter int unsigned MON_HOLD_CYC = aoc_pkg::MON_HOLD_CYC,
  parameter int unsigned ST_REC_CYC   = aoc_pkg::ST_REC_CYC
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sample_valid,
  input  wire logic [19:0] sample_data,
  input  wire logic        selftest_active,
  input  wire logic        acc_request,
  input  wire logic        req_corrected,
  output logic      [11:0] acc_word,
  output logic             acc_word_valid,
  output logic             irq
);

  // ==========================================================================
  // registers
  aoc_pkg::aoc_cfg_s   cfg_q;
  aoc_pkg::aoc_ctl_s   ctl_q;
  aoc_pkg::aoc_irq_s   istat_q, ien_q, ievt_w;
  aoc_pkg::aoc_phase_e auto_ph_q;
  logic [19:0]         uplim_q, lolim_q, corr_q, corr_d;
  logic [31:0]         prdata_q;
  logic                over_q;
  logic [12:0]         ds_cnt_q;
  logic [10:0]         ph_cnt_q;
  logic [12:0]         blk_cnt_q;
  logic [39:0]         blk_acc_q, win_q;
  logic [39:0]         blk_q [aoc_pkg::NUM_BLOCKS];
  logic [31:0]         mon_hold_q, rec_q;
  logic [19:0]         prev_q, pend_q;
  logic [20:0]         interp_q;
  logic [15:0]         per_cnt_q, half_q;
  logic [11:0]         word_q;
  logic                word_vld_q;
  // decimation keeps the newest upstream sample
  logic [19:0]         sample_hold_q;

  // ==========================================================================
  // suspension and phase selection
  wire logic susp_w = selftest_active || rec_q != 32'h0;
  wire logic ovr_w  = !ctl_q.init_done_flag && ctl_q.phase_override_enable;
  wire aoc_pkg::aoc_phase_e ph_w = ovr_w ? aoc_pkg::aoc_phase_e'(ctl_q.startup_phase_select) : auto_ph_q;

  // ==========================================================================
  // apb decode
  wire logic wr_w    = psel && penable && pwrite;
  wire logic setup_w = psel && !penable;
  wire logic hit_w   = paddr <= aoc_pkg::IRQ_EN_OFS && paddr[1:0] == 2'h0;
  wire logic wr_cfg  = wr_w && paddr == aoc_pkg::CFG_OFS;
  wire logic wr_ctl  = wr_w && paddr == aoc_pkg::CTL_OFS;
  wire logic wr_up   = wr_w && paddr == aoc_pkg::UPLIM_OFS;
  wire logic wr_lo   = wr_w && paddr == aoc_pkg::LOLIM_OFS;
  wire logic wr_clr  = wr_w && paddr == aoc_pkg::IRQ_CLR_OFS;
  wire logic wr_en   = wr_w && paddr == aoc_pkg::IRQ_EN_OFS;

  logic [31:0] rd_w;
  always_comb
  begin
    unique case (paddr)
      aoc_pkg::CFG_OFS:      rd_w = {30'h0, cfg_q};
      aoc_pkg::CTL_OFS:      rd_w = {28'h0, ctl_q};
      aoc_pkg::UPLIM_OFS:    rd_w = {12'h0, uplim_q};
      aoc_pkg::LOLIM_OFS:    rd_w = {12'h0, lolim_q};
      aoc_pkg::STAT_OFS:     rd_w = {28'h0, over_q, susp_w, ph_w};
      aoc_pkg::CORR_OFS:     rd_w = {12'h0, corr_q};
      aoc_pkg::IRQ_STAT_OFS: rd_w = {29'h0, istat_q};
      aoc_pkg::IRQ_EN_OFS:   rd_w = {29'h0, ien_q};
      default:               rd_w = 32'h0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_w;
  assign prdata  = prdata_q;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_q    <= aoc_pkg::CFG_RST;
      ctl_q    <= aoc_pkg::CTL_RST;
      uplim_q  <= aoc_pkg::UPLIM_RST;
      lolim_q  <= aoc_pkg::LOLIM_RST;
      ien_q    <= '0;
      prdata_q <= 32'h0;
    end
    else
    begin
      if (wr_cfg) cfg_q <= aoc_pkg::aoc_cfg_s'(pwdata[1:0]);
      if (wr_ctl) ctl_q <= aoc_pkg::aoc_ctl_s'(pwdata[3:0]);
      if (wr_up) uplim_q <= pwdata[19:0];
      if (wr_lo) lolim_q <= pwdata[19:0];
      if (wr_en) ien_q <= aoc_pkg::aoc_irq_s'(pwdata[2:0]);
      if (setup_w) prdata_q <= rd_w;
    end
  end

  // ==========================================================================
  // down-sampling and block averaging
  wire logic        tick_w    = ds_cnt_q == 13'(DS_CYC - 1);
  wire logic        ds_en_w   = tick_w && !susp_w;
  wire logic [3:0]  shift_w   = 4'(aoc_pkg::BLK_BASE_LOG2) + 4'(3 * ph_w);
  wire logic [12:0] blk_len_w = 13'(13'h1 << shift_w);
  wire logic        blk_end_w = ds_en_w && blk_cnt_q >= blk_len_w - 13'h1;
  wire logic [20:0] diff_w    = {sample_hold_q[19], sample_hold_q} - {corr_q[19], corr_q};
  wire logic [39:0] acc_nx_w  = blk_acc_q + {{19{diff_w[20]}}, diff_w};
  wire logic [39:0] win_nx_w  = win_q + acc_nx_w - blk_q[aoc_pkg::NUM_BLOCKS-1];
  wire logic [39:0] thr6_w    = ({20'h0, aoc_pkg::AVG_THR} * 40'(aoc_pkg::NUM_BLOCKS)) << shift_w;
  wire logic        hi_w      = $signed(win_nx_w) > $signed(thr6_w);
  wire logic        lo_w      = $signed(win_nx_w) < -$signed(thr6_w);
  wire logic        upd_w     = blk_end_w && (hi_w || lo_w);

  always_comb
  begin
    corr_d = corr_q;
    if (upd_w && hi_w) corr_d = corr_q + aoc_pkg::CORR_STEP;
    if (upd_w && lo_w) corr_d = corr_q - aoc_pkg::CORR_STEP;
  end

  // block sums form the running window
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ds_cnt_q      <= 13'h0;
      blk_cnt_q     <= 13'h0;
      blk_acc_q     <= 40'h0;
      win_q         <= 40'h0;
      corr_q        <= 20'h0;
      sample_hold_q <= 20'h0;
    end
    else
    begin
      ds_cnt_q <= tick_w ? 13'h0 : ds_cnt_q + 13'h1;
      if (sample_valid) sample_hold_q <= sample_data;
      if (blk_end_w)
      begin
        blk_cnt_q <= 13'h0;
        blk_acc_q <= 40'h0;
        win_q     <= win_nx_w;
      end
      else if (ds_en_w)
      begin
        blk_cnt_q <= blk_cnt_q + 13'h1;
        blk_acc_q <= acc_nx_w;
      end
      corr_q <= corr_d;
    end
  end

  // window history, shifted once per finished block
  for (genvar i = 0; i < aoc_pkg::NUM_BLOCKS; i++)
  begin : g_blk
    always_ff @(posedge mclk or negedge reset_n)
    begin
      if (!reset_n) blk_q[i] <= 40'h0;
      else if (blk_end_w) blk_q[i] <= (i == 0) ? acc_nx_w : blk_q[(i == 0) ? 0 : i - 1];
    end
  end

  // each start-up phase spans 2048 down-sampled ticks; PH_NORMAL is held
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      auto_ph_q <= aoc_pkg::PH_START1;
      ph_cnt_q  <= 11'h0;
    end
    else if (tick_w && auto_ph_q != aoc_pkg::PH_NORMAL)
    begin
      ph_cnt_q <= ph_cnt_q + 11'h1;
      if (ph_cnt_q == 11'(aoc_pkg::PHASE_SAMPLES - 1)) auto_ph_q <= aoc_pkg::aoc_phase_e'(auto_ph_q + 2'h1);
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rec_q      <= 32'h0;
      mon_hold_q <= 32'(MON_HOLD_CYC);
    end
    else
    begin
      if (selftest_active) rec_q <= 32'(ST_REC_CYC);
      else if (rec_q != 32'h0) rec_q <= rec_q - 32'h1;
      if (mon_hold_q != 32'h0) mon_hold_q <= mon_hold_q - 32'h1;
    end
  end

  // ==========================================================================
  // offset monitor
  wire logic mon_run_w = cfg_q.monitor_enable_bit && mon_hold_q == 32'h0;
  wire logic over_nx_w = $signed(corr_d) > $signed(uplim_q) || $signed(corr_d) < $signed(lolim_q);

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n) over_q <= 1'b0;
    else if (upd_w && mon_run_w) over_q <= over_nx_w;
  end

  // ==========================================================================
  // interrupts: set wins over clear
  assign ievt_w = '{corr_update: upd_w,
                    normal_reached: tick_w && ph_cnt_q == 11'(aoc_pkg::PHASE_SAMPLES - 1)
                                    && auto_ph_q == aoc_pkg::PH_START3,
                    over_range: upd_w && mon_run_w && over_nx_w};

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n) istat_q <= '0;
    else istat_q <= (istat_q & ~(wr_clr ? aoc_pkg::aoc_irq_s'(pwdata[2:0]) : '0)) | ievt_w;
  end

  assign irq = |(istat_q & ien_q);

  // ==========================================================================
  // interpolation and scaling
  function automatic logic [11:0] aoc_scale(input logic [20:0] v);
    logic [21:0] r;
    logic [17:0] q;
    r = {v[20], v} + 22'h8;
    q = r[21:4];
    if ($signed(q) > 18'sh007FF) return 12'h7FF;
    if ($signed(q) < -18'sh00800) return 12'h800;
    return q[11:0];
  endfunction : aoc_scale

  wire logic [20:0] sum_w    = {prev_q[19], prev_q} + {sample_data[19], sample_data};
  wire logic        use_c_w  = !cfg_q.cancel_disable_bit && req_corrected;
  wire logic [20:0] out_v_w  = use_c_w ? interp_q - {corr_q[19], corr_q} : interp_q;

  // mean now, sample itself half a period later
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prev_q    <= 20'h0;
      pend_q    <= 20'h0;
      interp_q  <= 21'h0;
      per_cnt_q <= 16'h0;
      half_q    <= 16'h0;
    end
    else if (sample_valid)
    begin
      prev_q    <= sample_data;
      pend_q    <= sample_data;
      interp_q  <= {sum_w[20], sum_w[20:1]};
      half_q    <= {1'b0, per_cnt_q[15:1]};
      per_cnt_q <= 16'h0;
    end
    else
    begin
      if (per_cnt_q != 16'hFFFF) per_cnt_q <= per_cnt_q + 16'h1;
      if (half_q == 16'h1) interp_q <= {pend_q[19], pend_q};
      if (half_q != 16'h0) half_q <= half_q - 16'h1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      word_q     <= 12'h0;
      word_vld_q <= 1'b0;
    end
    else
    begin
      word_vld_q <= acc_request;
      if (acc_request) word_q <= aoc_scale(out_v_w);
    end
  end

  assign acc_word       = word_q;
  assign acc_word_valid = word_vld_q;

  // ==========================================================================
  // checks
  sequence s_st_end;
    $fell(selftest_active);
  endsequence

  chk_corr_frozen_st: assert property (@(posedge mclk) disable iff (!reset_n)
    selftest_active |=> $stable(corr_q) && $stable(over_q))
    else $error("correction moved during self test");

  chk_recovery_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    s_st_end |-> susp_w [*8])
    else $error("cancellation resumed right after self test");

  chk_mon_holdoff: assert property (@(posedge mclk) disable iff (!reset_n)
    mon_hold_q != 32'h0 |=> !$rose(over_q))
    else $error("monitor flagged during hold-off");

  chk_mon_rate_only: assert property (@(posedge mclk) disable iff (!reset_n)
    $changed(over_q) |-> $past(upd_w))
    else $error("monitor changed without correction update");

  chk_mon_enable: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(over_q) |-> $past(cfg_q.monitor_enable_bit))
    else $error("monitor flagged while disabled");

  chk_over_limit: assert property (@(posedge mclk) disable iff (!reset_n)
    upd_w && mon_run_w && $signed(corr_d) > $signed(uplim_q) |=> over_q)
    else $error("over-range missed above upper limit");

  chk_phase_force: assert property (@(posedge mclk) disable iff (!reset_n)
    ovr_w |-> blk_len_w == 13'(13'h8 << (3 * ctl_q.startup_phase_select)))
    else $error("startup phase not forced");

  chk_interp_mean: assert property (@(posedge mclk) disable iff (!reset_n)
    sample_valid |=> interp_q == {$past(sum_w[20]), $past(sum_w[20:1])})
    else $error("interpolated mean wrong");

  chk_raw_select: assert property (@(posedge mclk) disable iff (!reset_n)
    acc_request && cfg_q.cancel_disable_bit |=> acc_word == aoc_scale($past(interp_q)))
    else $error("raw word not selected");

  chk_word_sat: assert property (@(posedge mclk) disable iff (!reset_n)
    acc_request && !out_v_w[20] && out_v_w[19:15] != 5'h0 |=> acc_word == 12'h7FF)
    else $error("positive over-range not saturated");

endmodule : aoc_path

//--- src/aoc_pkg.sv
// shared constants, types and register map of the offset cancel path
package aoc_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned DS_PERIOD_US  = 256;
  localparam int unsigned DS_CYC        = CLK_HZ / 1_000_000 * DS_PERIOD_US;
  localparam int unsigned PHASE_SAMPLES = 2048;
  localparam int unsigned MON_HOLD_MS   = 2100;
  localparam int unsigned MON_HOLD_CYC  = CLK_HZ / 1000 * MON_HOLD_MS;
  localparam int unsigned ST_REC_US     = 1000;
  localparam int unsigned ST_REC_CYC    = CLK_HZ / 1_000_000 * ST_REC_US;

  // ==========================================================================
  // averaging: window is six blocks, block length 8 << (3 * phase)
  localparam int unsigned NUM_BLOCKS    = 6;
  localparam int unsigned BLK_BASE_LOG2 = 3;
  localparam logic [19:0] AVG_THR       = 20'h00008;
  localparam logic [19:0] CORR_STEP     = 20'h00004;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] CFG_OFS      = 8'h00;
  localparam logic [7:0] CTL_OFS      = 8'h04;
  localparam logic [7:0] UPLIM_OFS    = 8'h08;
  localparam logic [7:0] LOLIM_OFS    = 8'h0C;
  localparam logic [7:0] STAT_OFS     = 8'h10;
  localparam logic [7:0] CORR_OFS     = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h18;
  localparam logic [7:0] IRQ_CLR_OFS  = 8'h1C;
  localparam logic [7:0] IRQ_EN_OFS   = 8'h20;

  localparam logic [19:0] UPLIM_RST = 20'h02000;
  localparam logic [19:0] LOLIM_RST = 20'hFE000;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {PH_START1, PH_START2, PH_START3, PH_NORMAL} aoc_phase_e;

  typedef struct packed {
    logic monitor_enable_bit;
    logic cancel_disable_bit;
  } aoc_cfg_s;

  typedef struct packed {
    logic       init_done_flag;
    logic       phase_override_enable;
    logic [1:0] startup_phase_select;
  } aoc_ctl_s;

  typedef struct packed {
    logic corr_update;
    logic normal_reached;
    logic over_range;
  } aoc_irq_s;

  localparam aoc_cfg_s CFG_RST = '{monitor_enable_bit: 1'b0, cancel_disable_bit: 1'b0};
  localparam aoc_ctl_s CTL_RST = '{init_done_flag: 1'b0, phase_override_enable: 1'b0,
                                   startup_phase_select: 2'h0};

endpackage : aoc_pkg

//--- verification/aoc_far_end.sv
// far-side model: upstream sample source and downstream request logic
`timescale 1ns/1ns
module aoc_far_end (
  input  wire logic        mclk,
  output logic             sample_valid,
  output logic      [19:0] sample_data,
  output logic             acc_request,
  output logic             req_corrected
);
  initial
  begin
    sample_valid = 1'b0;
    sample_data = 20'h00000;
    acc_request = 1'b0;
    req_corrected = 1'b0;
  end

  // ==========================================================================
  // stream source
  // data is inverted outside the pulse so a stale sample is never mistaken
  task automatic send(input logic [19:0] v);
    @(posedge mclk);
    sample_valid <= 1'b1;
    sample_data <= v;
    @(posedge mclk);
    sample_valid <= 1'b0;
    sample_data <= ~v;
  endtask : send

  // ==========================================================================
  // request strobe, one cycle, as on a chip-select rising edge
  task automatic request(input logic corr);
    @(posedge mclk);
    acc_request <= 1'b1;
    req_corrected <= corr;
    @(posedge mclk);
    acc_request <= 1'b0;
    req_corrected <= ~corr;
  endtask : request
endmodule : aoc_far_end

//--- verification/aoc_path_bench.sv
// self-checking bench for the offset cancel path
`timescale 1ns/1ns
module aoc_path_bench;
  localparam int DS = 4;
  localparam int LIMIT = 30000;
  logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        sv, av, rc, selftest_active, acc_word_valid, irq;
  logic [19:0] sd;
  logic [11:0] acc_word;
  int          failures, check_count, cyc;

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  aoc_path #(.DS_CYC(DS), .MON_HOLD_CYC(50), .ST_REC_CYC(20)) DUT (
    .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sv), .sample_data(sd), .selftest_active(selftest_active),
    .acc_request(av), .req_corrected(rc), .acc_word(acc_word),
    .acc_word_valid(acc_word_valid), .irq(irq)
  );
  aoc_far_end far (.mclk(mclk), .sample_valid(sv), .sample_data(sd), .acc_request(av), .req_corrected(rc));

  // ==========================================================================
  // shared tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    forever
    begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [11:0] scale(input int v);
    int r;
    r = (v + 8) >>> 4;
    if (r > 2047) r = 2047;
    if (r < -2048) r = -2048;
    return r[11:0];
  endfunction : scale

  task automatic req(input logic c, input logic [11:0] e, input string name);
    far.request(c);
    @(negedge mclk);
    chk("word valid", {31'h0, acc_word_valid}, 32'h1);
    chk(name, {20'h0, acc_word}, {20'h0, e});
    @(negedge mclk);
    chk("word valid drop", {31'h0, acc_word_valid}, 32'h0);
  endtask : req

  task automatic feed(input logic [19:0] v, input int n);
    repeat (n)
    begin
      far.send(v);
      repeat (3) @(posedge mclk);
    end
  endtask : feed

  // ==========================================================================
  // scenarios
  task automatic t_regs();
    logic [7:0]  a [0:5] = '{aoc_pkg::CFG_OFS, aoc_pkg::CTL_OFS, aoc_pkg::UPLIM_OFS,
                             aoc_pkg::LOLIM_OFS, aoc_pkg::CORR_OFS, aoc_pkg::IRQ_EN_OFS};
    logic [31:0] e [0:5] = '{32'h0, 32'h0, {12'h0, aoc_pkg::UPLIM_RST}, {12'h0, aoc_pkg::LOLIM_RST},
                             32'h0, 32'h0};
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, a[i], 32'h0);
      chk("reset value", rd, e[i]);
    end
    apb(1'b1, 8'h40, 32'hFFFFFFFF);
    chk("unmapped error", {31'h0, err}, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped read", rd, 32'h0);
    apb(1'b1, aoc_pkg::CTL_OFS, 32'h6);
    apb(1'b0, aoc_pkg::STAT_OFS, 32'h0);
    chk("forced phase", {30'h0, rd[1:0]}, 32'h2);
    apb(1'b1, aoc_pkg::CTL_OFS, 32'h5);
    apb(1'b0, aoc_pkg::STAT_OFS, 32'h0);
    chk("forced phase", {30'h0, rd[1:0]}, 32'h1);
    // init done: override must lose its grip
    apb(1'b1, aoc_pkg::CTL_OFS, 32'hE);
    apb(1'b0, aoc_pkg::STAT_OFS, 32'h0);
    chk("free phase", {30'h0, rd[1:0]}, 32'h0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_scale();
    logic [19:0] pa [0:4] = '{20'h00100, 20'h7FFF0, 20'h80010, 20'h00018, 20'h0FFF0};
    logic [19:0] pb [0:4] = '{20'h00300, 20'h7FFF0, 20'h80010, 20'hFFFE8, 20'h10010};
    int          m;
    for (int i = 0; i < 5; i++)
    begin
      far.send(pa[i]);
      repeat (20) @(posedge mclk);
      far.send(pb[i]);
      m = $signed(pa[i]) + $signed(pb[i]);
      req(1'b0, scale(m >>> 1), "interp mean");
      repeat (30) @(posedge mclk);
      req(1'b0, scale($signed(pb[i])), "scaled word");
    end
    $display("test scale done");
  endtask : t_scale

  task automatic t_monitor();
    apb(1'b1, aoc_pkg::UPLIM_OFS, 32'h10);
    apb(1'b1, aoc_pkg::IRQ_EN_OFS, 32'h1);
    feed(20'h00400, 200);
    apb(1'b0, aoc_pkg::STAT_OFS, 32'h0);
    chk("monitor off", {31'h0, rd[3]}, 32'h0);
    apb(1'b1, aoc_pkg::CFG_OFS, 32'h2);
    feed(20'h00400, 100);
    apb(1'b0, aoc_pkg::CORR_OFS, 32'h0);
    chk("corr step", {30'h0, rd[1:0]}, 32'h0);
    chk("corr grew", {31'h0, $signed(rd[19:0]) > 16}, 32'h1);
    apb(1'b0, aoc_pkg::STAT_OFS, 32'h0);
    chk("over-range", {31'h0, rd[3]}, 32'h1);
    @(negedge mclk);
    chk("irq raised", {31'h0, irq}, 32'h1);
    apb(1'b1, aoc_pkg::IRQ_EN_OFS, 32'h0);
    @(negedge mclk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    $display("test monitor done");
  endtask : t_monitor

  task automatic t_selftest();
    logic [31:0] c1;
    int          v;
    @(posedge mclk);
    selftest_active <= 1'b1;
    repeat (3) @(posedge mclk);
    apb(1'b0, aoc_pkg::CORR_OFS, 32'h0);
    c1 = rd;
    apb(1'b1, aoc_pkg::IRQ_CLR_OFS, 32'h4);
    feed(20'h00400, 60);
    apb(1'b0, aoc_pkg::CORR_OFS, 32'h0);
    chk("frozen corr", rd, c1);
    apb(1'b0, aoc_pkg::IRQ_STAT_OFS, 32'h0);
    chk("no update", {31'h0, rd[2]}, 32'h0);
    apb(1'b0, aoc_pkg::STAT_OFS, 32'h0);
    chk("suspended", {31'h0, rd[2]}, 32'h1);
    v = 1024 - $signed(c1[19:0]);
    req(1'b1, scale(v), "corrected word");
    req(1'b0, scale(1024), "raw word");
    apb(1'b1, aoc_pkg::CFG_OFS, 32'h3);
    req(1'b1, scale(1024), "disabled word");
    apb(1'b1, aoc_pkg::CFG_OFS, 32'h2);
    selftest_active <= 1'b0;
    apb(1'b0, aoc_pkg::STAT_OFS, 32'h0);
    chk("recovering", {31'h0, rd[2]}, 32'h1);
    repeat (30) @(posedge mclk);
    apb(1'b0, aoc_pkg::STAT_OFS, 32'h0);
    chk("resumed", {31'h0, rd[2]}, 32'h0);
    $display("test selftest done");
  endtask : t_selftest

  task automatic t_phase();
    wait (cyc >= 3 * aoc_pkg::PHASE_SAMPLES * DS - 100);
    apb(1'b0, aoc_pkg::STAT_OFS, 32'h0);
    chk("third phase", {30'h0, rd[1:0]}, 32'h2);
    wait (cyc >= 3 * aoc_pkg::PHASE_SAMPLES * DS + 100);
    apb(1'b0, aoc_pkg::STAT_OFS, 32'h0);
    chk("normal phase", {30'h0, rd[1:0]}, 32'h3);
    apb(1'b0, aoc_pkg::IRQ_STAT_OFS, 32'h0);
    chk("normal event", {31'h0, rd[1]}, 32'h1);
    $display("test phase done");
  endtask : t_phase

  // ==========================================================================
  // run control
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      failures++;
      end_sim();
    end
  end

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    selftest_active = 1'b0;
    reset_n = 1'b0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    t_regs();
    t_scale();
    t_monitor();
    t_selftest();
    t_phase();
    end_sim();
  end
endmodule : aoc_path_bench
